// file: pucl_params.svh
`ifndef PUCL_PARAMS_SVH
`define PUCL_PARAMS_SVH
`define PUCL_SYS_CLK_MHZ 200
`define PUCL_SCLK_MAX_MHZ 20
`define PUCL_SCLK_DIV ((`PUCL_SYS_CLK_MHZ + `PUCL_SCLK_MAX_MHZ - 1) / `PUCL_SCLK_MAX_MHZ)
`define PUCL_PH_LAST 4'(`PUCL_SCLK_DIV - 1)
`define PUCL_PH_RISE 4'(`PUCL_SCLK_DIV / 2 - 1)
`define PUCL_WAKE_WAIT_US 30
`define PUCL_WAKE_WAIT_CYC (`PUCL_WAKE_WAIT_US * `PUCL_SYS_CLK_MHZ)
`define PUCL_WAIT_W 13
`define PUCL_CMD_WAKE 8'hAB
`define PUCL_CMD_FAST_READ 8'h0B
`define PUCL_START_ADDR 24'h000000
`define PUCL_WAKE_PAD 24'h000000
`define PUCL_CMD_LAST_BIT 6'h07
`define PUCL_HDR_LAST_BIT 6'h1F
`define PUCL_DUMMY_LAST_BIT 6'h07
`define PUCL_BYTE_LAST_BIT 3'h7
`define PUCL_IMG_BYTES 256
`define PUCL_ADDR_W 8
`define PUCL_LAST_ADDR 8'hFF
`define PUCL_MASK_SEED 8'h5A
`endif

// file: pucl_pkg.sv
`include "pucl_params.svh"
package pucl_pkg;
	typedef enum logic [1:0] {PUCL_MODE_ACTIVE, PUCL_MODE_PASSIVE, PUCL_MODE_JTAG, PUCL_MODE_MASK} pucl_mode_t;
	typedef enum logic [3:0] {ST_IDLE, ST_WAKE, ST_WAKE_GAP, ST_RD_HDR, ST_DUMMY, ST_DATA, ST_PASSIVE,
		ST_JTAG, ST_MASK, ST_DONE} pucl_state_t;
	typedef struct packed {
		logic sclk;
		logic cs_b;
		logic mosi;
	} pucl_flash_t;
	typedef struct packed {
		logic cs_b;
		logic din;
	} pucl_pas_t;
	typedef struct packed {
		logic tck;
		logic tdi;
		logic sel;
	} pucl_jtag_t;
	typedef struct packed {
		logic en;
		logic [`PUCL_ADDR_W-1:0] addr;
		logic [7:0] data;
	} pucl_wr_t;
endpackage : pucl_pkg

// file: pucl_cfg_mem.sv
`timescale 1ns/1ps
`include "pucl_params.svh"
module pucl_cfg_mem
	import pucl_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire pucl_wr_t i_wr,
	input wire logic [`PUCL_ADDR_W-1:0] i_rd_addr,
	output logic [7:0] o_rd_data
);
	logic [7:0] mem [0:`PUCL_IMG_BYTES-1];

	always_ff @(posedge i_sys_clk)
	begin
		if (i_wr.en)
		begin
			mem[i_wr.addr] <= i_wr.data;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_rd_data <= 8'h00;
		end
		else
		begin
			o_rd_data <= mem[i_rd_addr];
		end
	end
endmodule : pucl_cfg_mem

// file: pucl_loader.sv
`timescale 1ns/1ps
`include "pucl_params.svh"
module pucl_loader
	import pucl_pkg::*;
#(
	parameter int unsigned P_WAKE_WAIT_CYC = `PUCL_WAKE_WAIT_CYC
)
(
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_config_reset_low,
	input wire logic [1:0] i_mode_pins,
	input wire logic i_flash_miso,
	input wire logic i_pas_clk,
	input wire pucl_pas_t i_pas,
	input wire pucl_jtag_t i_jtag,
	input wire logic [`PUCL_ADDR_W-1:0] i_cfg_rd_addr,
	output pucl_flash_t o_flash,
	output logic o_busy,
	output logic o_done,
	output logic [7:0] o_cfg_rd_data
);
	pucl_state_t state_reg, state_next;
	logic [2:0] crst_sync_reg;
	logic [1:0] mode_s1_reg, mode_s2_reg;
	logic [1:0] miso_sync_reg;
	pucl_jtag_t jtag_s1_reg, jtag_s2_reg;
	logic tck_prev_reg;
	logic [3:0] phase_reg;
	logic [5:0] bit_cnt_reg;
	logic [31:0] tx_reg, tx_next;
	logic [7:0] rx_reg;
	logic [`PUCL_WAIT_W-1:0] wait_cnt_reg;
	logic [`PUCL_ADDR_W-1:0] addr_cnt_reg;
	logic full_reg;
	pucl_wr_t wr_reg;
	logic [7:0] jsh_reg;
	logic [2:0] jbit_reg;
	logic [2:0] pas_bit_reg;
	logic [7:0] pas_sh_reg, pas_hold_reg;
	logic pas_tog_reg;
	logic [2:0] pas_tog_sync_reg;
	logic crst_rise, crst_low, clk_run, run_next, bit_end, tck_rise, pas_rdy, enter;

	assign crst_rise = crst_sync_reg[1] & ~crst_sync_reg[2];
	assign crst_low = ~crst_sync_reg[1];
	assign tck_rise = jtag_s2_reg.tck & ~tck_prev_reg;
	assign pas_rdy = pas_tog_sync_reg[1] ^ pas_tog_sync_reg[2];
	assign clk_run = (state_reg inside {ST_WAKE, ST_RD_HDR, ST_DUMMY, ST_DATA});
	assign run_next = (state_next inside {ST_WAKE, ST_RD_HDR, ST_DUMMY, ST_DATA});
	assign bit_end = clk_run && (phase_reg == `PUCL_PH_LAST);
	assign enter = (state_next != state_reg);

	// Pin synchronisers
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			crst_sync_reg <= 3'h0;
			mode_s1_reg <= 2'h0;
			mode_s2_reg <= 2'h0;
			miso_sync_reg <= 2'h0;
			jtag_s1_reg <= '0;
			jtag_s2_reg <= '0;
			tck_prev_reg <= 1'b0;
		end
		else
		begin
			crst_sync_reg <= {crst_sync_reg[1:0], i_config_reset_low};
			mode_s1_reg <= i_mode_pins;
			mode_s2_reg <= mode_s1_reg;
			miso_sync_reg <= {miso_sync_reg[0], i_flash_miso};
			jtag_s1_reg <= i_jtag;
			jtag_s2_reg <= jtag_s1_reg;
			tck_prev_reg <= jtag_s2_reg.tck;
		end
	end

	// Bit count clears on deselect even while the master's clock stands still
	always_ff @(posedge i_pas_clk or negedge i_rst_b or posedge i_pas.cs_b)
	begin
		if (!i_rst_b)
		begin
			pas_bit_reg <= 3'h0;
		end
		else if (i_pas.cs_b)
		begin
			pas_bit_reg <= 3'h0;
		end
		else
		begin
			pas_bit_reg <= pas_bit_reg + 3'h1;
		end
	end

	// Passive link: bytes assembled on the master's clock
	always_ff @(posedge i_pas_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			pas_sh_reg <= 8'h00;
			pas_hold_reg <= 8'h00;
			pas_tog_reg <= 1'b0;
		end
		else if (!i_pas.cs_b)
		begin
			pas_sh_reg <= {pas_sh_reg[6:0], i_pas.din};
			if (pas_bit_reg == `PUCL_BYTE_LAST_BIT)
			begin
				pas_hold_reg <= {pas_sh_reg[6:0], i_pas.din};
				pas_tog_reg <= ~pas_tog_reg;
			end
		end
	end

	// Byte event toggle into system clock
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			pas_tog_sync_reg <= 3'h0;
		end
		else
		begin
			pas_tog_sync_reg <= {pas_tog_sync_reg[1:0], pas_tog_reg};
		end
	end

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
			begin
				if (crst_rise)
				begin
					case (pucl_mode_t'(mode_s2_reg))
						PUCL_MODE_ACTIVE: state_next = ST_WAKE;
						PUCL_MODE_PASSIVE: state_next = ST_PASSIVE;
						PUCL_MODE_JTAG: state_next = ST_JTAG;
						PUCL_MODE_MASK: state_next = ST_MASK;
						default: state_next = ST_IDLE;
					endcase
				end
			end
			ST_WAKE:
			begin
				if (bit_end && bit_cnt_reg == `PUCL_CMD_LAST_BIT)
				begin
					state_next = ST_WAKE_GAP;
				end
			end
			ST_WAKE_GAP:
			begin
				if (wait_cnt_reg == `PUCL_WAIT_W'(P_WAKE_WAIT_CYC - 1))
				begin
					state_next = ST_RD_HDR;
				end
			end
			ST_RD_HDR:
			begin
				if (bit_end && bit_cnt_reg == `PUCL_HDR_LAST_BIT)
				begin
					state_next = ST_DUMMY;
				end
			end
			ST_DUMMY:
			begin
				if (bit_end && bit_cnt_reg == `PUCL_DUMMY_LAST_BIT)
				begin
					state_next = ST_DATA;
				end
			end
			ST_DATA, ST_PASSIVE, ST_JTAG, ST_MASK:
			begin
				if (full_reg)
				begin
					state_next = ST_DONE;
				end
			end
			ST_DONE: state_next = ST_DONE;
			default: state_next = ST_IDLE;
		endcase
		if (crst_low)
		begin
			state_next = ST_IDLE;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state_reg <= ST_IDLE;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// Command and address shifter
	always_comb
	begin
		tx_next = tx_reg;
		if (enter && state_next == ST_WAKE)
		begin
			tx_next = {`PUCL_CMD_WAKE, `PUCL_WAKE_PAD};
		end
		else if (enter && state_next == ST_RD_HDR)
		begin
			tx_next = {`PUCL_CMD_FAST_READ, `PUCL_START_ADDR};
		end
		else if (bit_end)
		begin
			tx_next = {tx_reg[30:0], 1'b0};
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			tx_reg <= 32'h00000000;
		end
		else
		begin
			tx_reg <= tx_next;
		end
	end

	// Serial clock divider and bit counter
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			phase_reg <= 4'h0;
			bit_cnt_reg <= 6'h00;
		end
		else if (enter || !run_next)
		begin
			phase_reg <= 4'h0;
			bit_cnt_reg <= 6'h00;
		end
		else
		begin
			phase_reg <= (phase_reg == `PUCL_PH_LAST) ? 4'h0 : phase_reg + 4'h1;
			if (bit_end)
			begin
				bit_cnt_reg <= bit_cnt_reg + 6'h01;
			end
		end
	end

	// Flash pins, all registered
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_flash <= '{sclk: 1'b0, cs_b: 1'b1, mosi: 1'b0};
		end
		else
		begin
			o_flash.cs_b <= ~run_next;
			o_flash.mosi <= tx_next[31];
			if (enter || !run_next)
			begin
				o_flash.sclk <= 1'b0;
			end
			else if (phase_reg == `PUCL_PH_RISE)
			begin
				o_flash.sclk <= 1'b1;
			end
			else if (phase_reg == `PUCL_PH_LAST)
			begin
				o_flash.sclk <= 1'b0;
			end
		end
	end

	// Wake-up gap timer
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			wait_cnt_reg <= '0;
		end
		else if (state_reg == ST_WAKE_GAP && !enter)
		begin
			wait_cnt_reg <= wait_cnt_reg + `PUCL_WAIT_W'(1);
		end
		else
		begin
			wait_cnt_reg <= '0;
		end
	end

	// Serial receivers for flash and boundary-scan data
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			rx_reg <= 8'h00;
			jsh_reg <= 8'h00;
			jbit_reg <= 3'h0;
		end
		else
		begin
			if (state_reg == ST_DATA && bit_end)
			begin
				rx_reg <= {rx_reg[6:0], miso_sync_reg[1]};
			end
			if (state_reg != ST_JTAG)
			begin
				jbit_reg <= 3'h0;
			end
			else if (tck_rise && jtag_s2_reg.sel)
			begin
				jsh_reg <= {jsh_reg[6:0], jtag_s2_reg.tdi};
				jbit_reg <= jbit_reg + 3'h1;
			end
		end
	end

	// Writes into configuration memory
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			wr_reg <= '0;
			addr_cnt_reg <= '0;
			full_reg <= 1'b0;
		end
		else if (state_reg inside {ST_IDLE, ST_DONE})
		begin
			wr_reg.en <= 1'b0;
			addr_cnt_reg <= '0;
			full_reg <= 1'b0;
		end
		else
		begin
			wr_reg.en <= 1'b0;
			wr_reg.addr <= addr_cnt_reg;
			if (!full_reg)
			begin
				case (state_reg)
					ST_DATA:
					begin
						wr_reg.en <= bit_end && (bit_cnt_reg[2:0] == `PUCL_BYTE_LAST_BIT);
						wr_reg.data <= {rx_reg[6:0], miso_sync_reg[1]};
					end
					ST_PASSIVE:
					begin
						wr_reg.en <= pas_rdy;
						wr_reg.data <= pas_hold_reg;
					end
					ST_JTAG:
					begin
						wr_reg.en <= tck_rise && jtag_s2_reg.sel && (jbit_reg == `PUCL_BYTE_LAST_BIT);
						wr_reg.data <= {jsh_reg[6:0], jtag_s2_reg.tdi};
					end
					ST_MASK:
					begin
						wr_reg.en <= 1'b1;
						wr_reg.data <= addr_cnt_reg ^ `PUCL_MASK_SEED;
					end
					default: wr_reg.en <= 1'b0;
				endcase
			end
			if (wr_reg.en)
			begin
				addr_cnt_reg <= addr_cnt_reg + `PUCL_ADDR_W'(1);
				full_reg <= (addr_cnt_reg == `PUCL_LAST_ADDR);
			end
		end
	end

	// Status
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end
		else
		begin
			o_busy <= !(state_next inside {ST_IDLE, ST_DONE});
			o_done <= (state_next == ST_DONE);
		end
	end

	pucl_cfg_mem u_cfg_mem (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_wr(wr_reg),
		.i_rd_addr(i_cfg_rd_addr),
		.o_rd_data(o_cfg_rd_data)
	);

	// Checks
	logic [`PUCL_WAIT_W-1:0] gap_cnt_reg;
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			gap_cnt_reg <= '0;
		end
		else if (!o_flash.cs_b)
		begin
			gap_cnt_reg <= '0;
		end
		else if (gap_cnt_reg != '1)
		begin
			gap_cnt_reg <= gap_cnt_reg + `PUCL_WAIT_W'(1);
		end
	end

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_b);

	property p_start_active;
		state_reg == ST_IDLE && crst_rise && pucl_mode_t'(mode_s2_reg) == PUCL_MODE_ACTIVE
			|=> state_reg == ST_WAKE && !o_flash.cs_b;
	endproperty
	a_start_active: assert property (p_start_active) else $error("active load did not start");
	property p_wake_first;
		$changed(state_reg) && state_reg == ST_WAKE |-> $past(state_reg) == ST_IDLE && tx_reg[31:24] == `PUCL_CMD_WAKE;
	endproperty
	a_wake_first: assert property (p_wake_first) else $error("first command not wake");
	property p_wake_gap;
		$fell(o_flash.cs_b) && state_reg == ST_RD_HDR |-> gap_cnt_reg >= `PUCL_WAIT_W'(P_WAKE_WAIT_CYC);
	endproperty
	a_wake_gap: assert property (p_wake_gap) else $error("wake gap too short");
	property p_fast_read;
		$changed(state_reg) && state_reg == ST_RD_HDR
			|-> tx_reg == {`PUCL_CMD_FAST_READ, `PUCL_START_ADDR} && o_flash.mosi == 1'b0;
	endproperty
	a_fast_read: assert property (p_fast_read) else $error("bad fast read header");
	// A config reset drop may cut a high phase short
	property p_sclk_high;
		disable iff (!i_rst_b || crst_low)
		$rose(o_flash.sclk) |-> o_flash.sclk [*5] ##1 !o_flash.sclk;
	endproperty
	a_sclk_high: assert property (p_sclk_high) else $error("serial clock high too short");
	property p_sclk_low;
		$fell(o_flash.sclk) |-> !o_flash.sclk [*5];
	endproperty
	a_sclk_low: assert property (p_sclk_low) else $error("serial clock low too short");
	property p_cs_held;
		state_reg inside {ST_RD_HDR, ST_DUMMY, ST_DATA} |-> !o_flash.cs_b;
	endproperty
	a_cs_held: assert property (p_cs_held) else $error("flash deselected during read");
	property p_flash_quiet;
		state_reg inside {ST_IDLE, ST_PASSIVE, ST_JTAG, ST_MASK, ST_DONE} |=> o_flash.cs_b || state_reg == ST_WAKE;
	endproperty
	a_flash_quiet: assert property (p_flash_quiet) else $error("flash driven outside active load");
	property p_byte_store;
		state_reg == ST_DATA && bit_end && bit_cnt_reg[2:0] == `PUCL_BYTE_LAST_BIT && !full_reg
			|=> wr_reg.en && wr_reg.data == {$past(rx_reg[6:0]), $past(miso_sync_reg[1])};
	endproperty
	a_byte_store: assert property (p_byte_store) else $error("flash byte not stored");
	property p_done_full;
		$rose(o_done) |-> $past(full_reg) ##1 o_flash.cs_b;
	endproperty
	a_done_full: assert property (p_done_full) else $error("done before image loaded");
	property p_mask_load;
		state_reg == ST_MASK && !full_reg && !crst_low |=> wr_reg.en && wr_reg.data == (wr_reg.addr ^ `PUCL_MASK_SEED);
	endproperty
	a_mask_load: assert property (p_mask_load) else $error("mask byte not written");
	c_active_done: cover property ($past(state_reg) == ST_DATA && state_reg == ST_DONE);
	c_passive_done: cover property ($past(state_reg) == ST_PASSIVE && state_reg == ST_DONE);
	c_jtag_byte: cover property (state_reg == ST_JTAG && wr_reg.en);
endmodule : pucl_loader

// file: pucl_flash_model.sv
`timescale 1ns/1ps
module pucl_flash_model
(
	input wire logic i_sclk,
	input wire logic i_cs_b,
	input wire logic i_mosi,
	input wire logic i_slow,
	input wire logic i_clr,
	output logic o_miso,
	output logic [7:0] o_first_cmd,
	output logic [31:0] o_rd_hdr
);
	int nbit;
	int nfr;
	int b;
	logic [31:0] sh;
	logic [7:0] cur;
	initial
	begin
		o_miso = 1'b0;
		nbit = 0;
		nfr = 0;
	end
	always @(posedge i_clr)
		nfr = 0;
	always @(negedge i_cs_b)
		nbit = 0;
	// Deselected output no longer holds the last bit
	// Frames are not counted while the bench holds clear, so reset edges on the select are ignored
	always @(posedge i_cs_b)
	begin
		if (!i_clr)
			nfr++;
		o_miso <= #2 ~o_miso;
	end
	// Capture the wake frame and the read header
	always @(posedge i_sclk)
		if (!i_cs_b)
		begin
			sh = {sh[30:0], i_mosi};
			nbit++;
			if (nfr == 0 && nbit == 8)
				o_first_cmd = sh[7:0];
			if (nfr == 1 && nbit == 32)
				o_rd_hdr = sh;
		end
	// Byte k holds k*37+11, MSB first after the dummy clocks
	always @(negedge i_sclk)
		if (!i_cs_b && nbit >= 40)
		begin
			b = nbit - 40;
			cur = 8'((b / 8) * 37 + 11);
			o_miso <= #(i_slow ? 12 : 1) cur[7 - b % 8];
		end
endmodule : pucl_flash_model

// file: pucl_loader_bench.sv
`timescale 1ns/1ps
`include "pucl_params.svh"
module pucl_loader_bench;
	import pucl_pkg::*;
	localparam int unsigned WAKE = 20;
	logic i_sys_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_config_reset_low = 1'b1;
	logic [1:0] i_mode_pins = 2'h0;
	logic i_flash_miso;
	logic i_pas_clk = 1'b0;
	pucl_pas_t i_pas = '{cs_b: 1'b1, din: 1'b0};
	pucl_jtag_t i_jtag = '0;
	logic [7:0] i_cfg_rd_addr = 8'h00;
	pucl_flash_t o_flash;
	logic o_busy;
	logic o_done;
	logic [7:0] o_cfg_rd_data;
	logic slow = 1'b0;
	logic clr = 1'b1;
	logic sclk_d = 1'b0;
	logic [7:0] first_cmd;
	logic [31:0] rd_hdr;
	logic [7:0] img [256];
	int n_fail = 0;
	int samples_checked = 0;
	int hi_run = 0;
	int last_gap = 0;
	int lvl_run = 0;
	int min_half = 999;

	pucl_loader #(.P_WAKE_WAIT_CYC(WAKE)) u_dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
		.i_config_reset_low(i_config_reset_low), .i_mode_pins(i_mode_pins), .i_flash_miso(i_flash_miso),
		.i_pas_clk(i_pas_clk), .i_pas(i_pas), .i_jtag(i_jtag), .i_cfg_rd_addr(i_cfg_rd_addr),
		.o_flash(o_flash), .o_busy(o_busy), .o_done(o_done), .o_cfg_rd_data(o_cfg_rd_data));
	pucl_flash_model u_flash (.i_sclk(o_flash.sclk), .i_cs_b(o_flash.cs_b), .i_mosi(o_flash.mosi),
		.i_slow(slow), .i_clr(clr), .o_miso(i_flash_miso), .o_first_cmd(first_cmd), .o_rd_hdr(rd_hdr));

	always #2.5 i_sys_clk = ~i_sys_clk;

	// Deselect gap length and shortest flash clock phase
	always @(posedge i_sys_clk)
	begin
		if (o_flash.cs_b === 1'b1)
			hi_run++;
		else
		begin
			if (hi_run > 0)
				last_gap = hi_run;
			hi_run = 0;
		end
		if (o_flash.sclk !== sclk_d)
		begin
			if (o_flash.cs_b === 1'b0 && lvl_run < min_half)
				min_half = lvl_run;
			lvl_run = 1;
		end
		else
			lvl_run++;
		sclk_d = o_flash.sclk;
	end

	function automatic logic [7:0] flash_byte(input int k);
		return 8'(k * 37 + 11);
	endfunction : flash_byte

	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask : tick

	task automatic wrap_up;
		if (n_fail == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wait_done;
		for (int i = 0; i < 60000 && o_done !== 1'b1; i++)
			tick(1);
		if (o_done !== 1'b1)
		begin
			chk("done_timeout", 32'h1, 32'(o_done));
			wrap_up();
		end
	endtask : wait_done

	task automatic start(input logic [1:0] m);
		i_config_reset_low = 1'b0;
		i_mode_pins = m;
		tick(6);
		i_config_reset_low = 1'b1;
		tick(8);
	endtask : start

	task automatic chk_mem(input string nm);
		for (int a = 0; a < 256; a++)
		begin
			i_cfg_rd_addr = 8'(a);
			tick(1);
			chk(nm, 32'(img[a]), 32'(o_cfg_rd_data));
		end
	endtask : chk_mem

	// Link clock runs only inside the frame
	task automatic pas_frame(input int nbits);
		i_pas.cs_b = 1'b0;
		#3;
		for (int i = 0; i < nbits; i++)
		begin
			i_pas.din = img[(i / 8) % 256][7 - i % 8];
			#3 i_pas_clk = 1'b1;
			#3 i_pas_clk = 1'b0;
		end
		#3 i_pas.cs_b = 1'b1;
		i_pas.din = ~i_pas.din;
		tick(2);
	endtask : pas_frame

	initial
	begin
		void'($urandom(14));
		tick(6);
		chk("cs_b_in_reset", 32'h1, 32'(o_flash.cs_b));
		i_rst_b = 1'b1;
		clr = 1'b0;
		for (int r = 0; r < 2; r++)
		begin
			min_half = 999;
			if (r == 1)
			begin
				slow = 1'b1;
				clr = 1'b1;
				start(2'h0);
				clr = 1'b0;
			end
			wait_done();
			chk("first_cmd", 32'(`PUCL_CMD_WAKE), 32'(first_cmd));
			chk("read_hdr", {`PUCL_CMD_FAST_READ, `PUCL_START_ADDR}, rd_hdr);
			chk("wake_gap_ok", 32'h1, 32'(last_gap >= WAKE));
			chk("sclk_phase_ok", 32'h1, 32'(min_half >= 5));
			chk("cs_b_after_load", 32'h1, 32'(o_flash.cs_b));
			for (int k = 0; k < 256; k++)
				img[k] = flash_byte(k);
			chk_mem("active_mem");
		end
		// Abort mid-load
		start(2'h0);
		tick(300);
		chk("busy_loading", 32'h1, 32'(o_busy));
		i_config_reset_low = 1'b0;
		tick(4);
		chk("busy_abort", 32'h0, 32'(o_busy));
		chk("done_abort", 32'h0, 32'(o_done));
		chk("cs_b_abort", 32'h1, 32'(o_flash.cs_b));
		for (int k = 0; k < 256; k++)
			img[k] = 8'($urandom);
		start(2'h1);
		pas_frame(3);
		pas_frame(2056);
		wait_done();
		chk_mem("passive_mem");
		for (int k = 0; k < 256; k++)
			img[k] = 8'($urandom);
		start(2'h2);
		i_jtag.sel = 1'b1;
		for (int i = 0; i < 2048; i++)
		begin
			i_jtag.tdi = img[i / 8][7 - i % 8];
			tick(3);
			i_jtag.tck = 1'b1;
			tick(3);
			i_jtag.tck = 1'b0;
		end
		i_jtag.sel = 1'b0;
		wait_done();
		chk_mem("jtag_mem");
		start(2'h3);
		wait_done();
		for (int k = 0; k < 256; k++)
			img[k] = 8'(k) ^ `PUCL_MASK_SEED;
		chk_mem("mask_mem");
		wrap_up();
	end
endmodule : pucl_loader_bench
